//--- shared/adcd_pkg.sv
// Purpose: constants and types for the chained converter readout core
// Assumes: core clock of 100 MHz, all pins asynchronous to it
// Notes: serial clock and convert start are sampled, never used as clocks
//
// Overview of operation
// - The last chained converter shows conversion-complete busy on its data out for the host.
// - The result sits in a shift register, read out with convert start low, one bit per fall.
// - Each serial clock fall during acquisition with convert start low loads the chain input from the previous converter into the shifter.
// - Each result is an 18-bit code from all zeros to all ones.
// - A convert start rise ends acquisition and starts a conversion that ends only once its time has run out and a result is waiting.
// - When conversion ends the busy indication goes onto data out and acquisition resumes.
// - Each converter sends its result most significant bit first.
package adcd_pkg;

  // ----------------------------------------------------------------
  // widths and codes
  // ----------------------------------------------------------------
  localparam int DATA_W = 18;
  localparam int CHAIN_W = DATA_W + 1; // busy bit plus result
  localparam logic [DATA_W-1:0] CODE_MIN = 18'h00000;
  localparam logic [DATA_W-1:0] CODE_MAX = 18'h3ffff;
  localparam int FIFO_DEPTH = 32;
  localparam int READ_FALLS_PER_DEV = 18;

  // ----------------------------------------------------------------
  // levels and reset values
  // ----------------------------------------------------------------
  localparam logic BUSY_DONE_LVL = 1'b0; // falling level raises host interrupt
  localparam logic BUSY_ACTIVE_LVL = 1'b1; // driven while converting
  localparam logic [CHAIN_W-1:0] SR_RST = 19'h7ffff;
  localparam logic [2:0] SYNC3_RST = 3'h0;
  localparam logic [1:0] SYNC2_RST = 2'h0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int HOST_WAIT_NS = 50; // host side only
  localparam int CONV_TIME_NS = 2000;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CONV_CYCLES =
    CNT_W'((CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CNT_RST = 8'h00;

  // ----------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    ST_ACQ = 1'b0,
    ST_CONV = 1'b1
  } adcd_state_t;

  typedef struct packed {
    adcd_state_t st;
    logic [2:0] cnv_sync;
    logic [2:0] sclk_sync;
    logic [1:0] din_sync;
    logic [CNT_W-1:0] cnt;
    logic [CHAIN_W-1:0] sr;
    logic dout;
    logic dout_oe;
  } adcd_core_t;

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] data;
  } adcd_sample_t;

endpackage : adcd_pkg

//--- src/adcd_fifo.sv
// Purpose: sample buffer between the conversion source and the shifter
// Assumes: single clock, synchronous active-low reset
// Notes: read data come from a register; capacity is DEPTH plus the output stage
module adcd_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] cnt;
    logic in_ready;
    logic out_valid;
    logic [WIDTH-1:0] out_data;
  } adcd_fifo_t;

  logic [WIDTH-1:0] mem [DEPTH];
  adcd_fifo_t s_q;
  adcd_fifo_t s_d;
  logic push;
  logic pop;
  logic load;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    push = in_valid & s_q.in_ready;
    pop = s_q.out_valid & out_ready;
    load = (~s_q.out_valid | pop) & (s_q.cnt != '0);
    if (push) begin
      s_d.wr_ptr = AW'(s_q.wr_ptr + 1'b1);
    end
    if (load) begin
      s_d.rd_ptr = AW'(s_q.rd_ptr + 1'b1);
      s_d.out_data = mem[s_q.rd_ptr];
    end
    s_d.out_valid = load | (s_q.out_valid & ~pop);
    s_d.cnt = (AW+1)'(s_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, load});
    s_d.in_ready = (s_d.cnt != FULL_CNT); // honest back-pressure
  end

  // state register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[s_q.wr_ptr] <= in_data;
    end
  end

  assign in_ready = s_q.in_ready;
  assign out_valid = s_q.out_valid;
  assign out_data = s_q.out_data;

endmodule : adcd_fifo

//--- src/adcd_core.sv
// Purpose: daisy-chain readout with busy indicator for one 18-bit converter
// Assumes: pins are asynchronous and pass two flip-flops before use
// Notes: serial clock falls are found by sampling at the core clock
module adcd_core (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // conversion results from the converter array
  input wire logic SAMPLE_VALID,
  input wire logic [adcd_pkg::DATA_W-1:0] SAMPLE_DATA,
  output logic SAMPLE_READY,
  // serial pins
  input wire logic CONVERT_START,
  input wire logic SCLK,
  input wire logic DIN,
  output logic DOUT,
  output logic DOUT_OE
);
  adcd_pkg::adcd_core_t s_q;
  adcd_pkg::adcd_core_t s_d;
  adcd_pkg::adcd_sample_t smp;
  logic smp_ready;
  logic cnv_rise;
  logic cnv_low;
  logic sclk_fall;

  // ----------------------------------------------------------------
  // sample buffer
  // ----------------------------------------------------------------
  adcd_fifo #(
    .WIDTH(adcd_pkg::DATA_W),
    .DEPTH(adcd_pkg::FIFO_DEPTH)
  ) u_adcd_fifo (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .in_valid(SAMPLE_VALID),
    .in_data(SAMPLE_DATA),
    .in_ready(SAMPLE_READY),
    .out_valid(smp.valid),
    .out_data(smp.data),
    .out_ready(smp_ready)
  );

  // ----------------------------------------------------------------
  // pin edge detection, second and third stages only
  // ----------------------------------------------------------------
  assign cnv_rise = s_q.cnv_sync[1] & ~s_q.cnv_sync[2];
  assign cnv_low = ~s_q.cnv_sync[1];
  assign sclk_fall = ~s_q.sclk_sync[1] & s_q.sclk_sync[2];
  // result taken only when the conversion time has run out
  assign smp_ready = (s_q.st == adcd_pkg::ST_CONV) && (s_q.cnt == adcd_pkg::CNT_RST);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.cnv_sync = {s_q.cnv_sync[1:0], CONVERT_START};
    s_d.sclk_sync = {s_q.sclk_sync[1:0], SCLK};
    s_d.din_sync = {s_q.din_sync[0], DIN};
    s_d.dout_oe = 1'b1; // chain output always driven
    case (s_q.st)
      adcd_pkg::ST_ACQ: begin
        if (cnv_rise) begin
          s_d.st = adcd_pkg::ST_CONV;
          s_d.cnt = adcd_pkg::CONV_CYCLES;
          s_d.sr = adcd_pkg::SR_RST;
        end else if (cnv_low && sclk_fall) begin
          s_d.sr = {s_q.sr[adcd_pkg::CHAIN_W-2:0], s_q.din_sync[1]};
        end
      end
      adcd_pkg::ST_CONV: begin
        // convert start is ignored until the conversion completes
        if (s_q.cnt != adcd_pkg::CNT_RST) begin
          s_d.cnt = adcd_pkg::CNT_W'(s_q.cnt - 1'b1);
        end else if (smp.valid) begin
          s_d.st = adcd_pkg::ST_ACQ;
          s_d.sr = {adcd_pkg::BUSY_DONE_LVL, smp.data}; // msb next after busy
        end
      end
      default: begin
        s_d.st = adcd_pkg::ST_ACQ;
      end
    endcase
    // busy level while converting, else the shifter head
    s_d.dout = (s_d.st == adcd_pkg::ST_CONV) ? adcd_pkg::BUSY_ACTIVE_LVL
                                             : s_d.sr[adcd_pkg::CHAIN_W-1];
  end

  // state register
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      s_q.st <= adcd_pkg::ST_ACQ;
      s_q.cnv_sync <= adcd_pkg::SYNC3_RST;
      s_q.sclk_sync <= adcd_pkg::SYNC3_RST;
      s_q.din_sync <= adcd_pkg::SYNC2_RST;
      s_q.cnt <= adcd_pkg::CNT_RST;
      s_q.sr <= adcd_pkg::SR_RST;
      s_q.dout <= adcd_pkg::BUSY_ACTIVE_LVL;
      s_q.dout_oe <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign DOUT = s_q.dout;
  assign DOUT_OE = s_q.dout_oe;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_busy_on_done: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (s_q.st == adcd_pkg::ST_CONV) && smp_ready && smp.valid
    |=> (DOUT == adcd_pkg::BUSY_DONE_LVL) && DOUT_OE)
    else $error("busy indication missing after conversion");

  a_shift_on_fall: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (s_q.st == adcd_pkg::ST_ACQ) && cnv_low && sclk_fall && !cnv_rise
    |=> DOUT == $past(s_q.sr[adcd_pkg::CHAIN_W-2]))
    else $error("data out did not advance on serial clock fall");

  a_chain_in_load: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (s_q.st == adcd_pkg::ST_ACQ) && cnv_low && sclk_fall && !cnv_rise
    |=> s_q.sr[0] == $past(s_q.din_sync[1]))
    else $error("chain input not loaded into shifter");

  a_hold_no_fall: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (s_q.st == adcd_pkg::ST_ACQ) && !sclk_fall && !cnv_rise |=> $stable(s_q.sr))
    else $error("shifter moved without a serial clock fall");

  a_conv_start: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (s_q.st == adcd_pkg::ST_ACQ) && cnv_rise
    |=> (s_q.st == adcd_pkg::ST_CONV) && (s_q.cnt == adcd_pkg::CONV_CYCLES) && DOUT)
    else $error("conversion did not start on convert start rise");

  a_conv_runs: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (s_q.st == adcd_pkg::ST_CONV) && (s_q.cnt != adcd_pkg::CNT_RST)
    |=> (s_q.st == adcd_pkg::ST_CONV) && (s_q.cnt == $past(s_q.cnt) - 8'h01))
    else $error("conversion interrupted before completion");

  a_return_acq: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    smp_ready && smp.valid |=> s_q.st == adcd_pkg::ST_ACQ)
    else $error("no return to acquisition after conversion");

  a_msb_first: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    smp_ready && smp.valid
    |=> s_q.sr[adcd_pkg::DATA_W-1:0] == $past(smp.data)
        && s_q.sr[adcd_pkg::DATA_W-1] == $past(smp.data[adcd_pkg::DATA_W-1]))
    else $error("result not loaded msb first");

  // ----------------------------------------------------------------
  // checks on reset and pin levels
  // ----------------------------------------------------------------
  // outputs sit at their reset levels while reset is held
  a_reset_levels: assert property (@(posedge CORE_CLK)
    !RST_N
    |=> !DOUT_OE && (DOUT == adcd_pkg::BUSY_ACTIVE_LVL) && !SAMPLE_READY)
    else $error("outputs not at reset levels");

  // once out of reset the chain output is never released
  a_oe_driven: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    $past(RST_N)
    |-> DOUT_OE)
    else $error("chain output released outside reset");

  a_busy_in_conv: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    s_q.st == adcd_pkg::ST_CONV
    |-> (DOUT == adcd_pkg::BUSY_ACTIVE_LVL) && DOUT_OE)
    else $error("busy level missing while converting");

  a_dout_steady: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (s_q.st == adcd_pkg::ST_ACQ) && !sclk_fall && !cnv_rise
    |=> $stable(DOUT))
    else $error("data out changed without a serial clock fall");

  a_hold_start_high: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (s_q.st == adcd_pkg::ST_ACQ) && !cnv_low && !cnv_rise
    |=> $stable(s_q.sr))
    else $error("shifter moved while convert start was high");

  // ----------------------------------------------------------------
  // checks on conversion timing
  // ----------------------------------------------------------------
  // the delay below equals CONV_CYCLES; keep the two in step
  a_conv_length: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (s_q.st == adcd_pkg::ST_ACQ) && cnv_rise
    |=> ##200 (s_q.st == adcd_pkg::ST_CONV) && (s_q.cnt == adcd_pkg::CNT_RST))
    else $error("conversion time not as configured");

  // a second rise while busy must not reload the counter
  a_start_ignored: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (s_q.st == adcd_pkg::ST_CONV) && (s_q.cnt != adcd_pkg::CNT_RST) && cnv_rise
    |=> (s_q.st == adcd_pkg::ST_CONV) && (s_q.cnt != adcd_pkg::CONV_CYCLES))
    else $error("convert start rise restarted a running conversion");

  a_start_fills: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (s_q.st == adcd_pkg::ST_ACQ) && cnv_rise
    |=> s_q.sr == adcd_pkg::SR_RST)
    else $error("shifter not preset at conversion start");

  a_acq_count_idle: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    s_q.st == adcd_pkg::ST_ACQ
    |-> s_q.cnt == adcd_pkg::CNT_RST)
    else $error("conversion counter running during acquisition");

  a_conv_frozen: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (s_q.st == adcd_pkg::ST_CONV) && !(smp_ready && smp.valid)
    |=> $stable(s_q.sr))
    else $error("shifter moved during conversion");

  // with no result waiting the busy level holds, never a stale code
  a_stall_empty: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    smp_ready && !smp.valid
    |=> (s_q.st == adcd_pkg::ST_CONV) && (DOUT == adcd_pkg::BUSY_ACTIVE_LVL))
    else $error("conversion ended without a result");

  a_one_pop: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    smp_ready && smp.valid
    |=> !smp_ready)
    else $error("more than one result taken per conversion");

endmodule : adcd_core

//--- sim/adcd_host_model.sv
// Purpose: host and previous chained converter on the serial pins
// Assumes: pins change at core clock rises, serial clock period 80 ns
// Notes: data from the previous converter toggles every cycle outside frames
module adcd_host_model (
  // reference clock
  input wire logic clk,
  // serial pins
  output logic cnv,
  output logic sclk,
  output logic din,
  input wire logic dout
);
  timeunit 1ns;
  timeprecision 1ps;
  logic framing = 1'b0;
  initial begin
    cnv = 1'b0;
    sclk = 1'b1;
    din = 1'b0;
  end
  // released chain input: never holds its last value
  always @(posedge clk) begin
    if (!framing) din <= ~din;
  end
  // start, bounce the start pin, wait for busy done, then hold off
  task automatic convert(output int waited);
    @(posedge clk) cnv <= 1'b1;
    repeat (10) @(posedge clk);
    cnv <= 1'b0;
    repeat (10) @(posedge clk);
    cnv <= 1'b1; // second rise while converting
    repeat (10) @(posedge clk);
    cnv <= 1'b0;
    waited = 30;
    while (dout !== 1'b0 && waited < 600) begin
      @(posedge clk);
      waited++;
    end
    repeat (adcd_pkg::HOST_WAIT_NS / adcd_pkg::CLK_PERIOD_NS) @(posedge clk);
  endtask : convert
  // two-device frame: 18 x 2 + 1 falls, sclk idles high
  task automatic read(input logic [18:0] prev, output logic [36:0] got);
    logic [18:0] s;
    s = prev;
    got = '0;
    framing <= 1'b1;
    @(posedge clk) din <= s[18];
    for (int i = 0; i < 37; i++) begin
      @(posedge clk) sclk <= 1'b0;
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      s = {s[17:0], ~s[0]};
      din <= s[18]; // previous converter moves on after the fall
      repeat (3) @(posedge clk); // next fall at the following edge: 80 ns period
      got = {got[35:0], dout};
    end
    framing <= 1'b0;
  endtask : read
endmodule : adcd_host_model

//--- sim/tb_adcd_core.sv
// Purpose: self-checking bench for the chained converter readout core
// Assumes: host model drives the serial pins, bench feeds samples
// Notes: fifo filled to refusal, then drained by conversions
module tb_adcd_core;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic sample_valid = 1'b0;
  logic [17:0] sample_data = '0;
  logic sample_ready, convert_start, sclk, din, dout, dout_oe;
  int mismatches = 0;
  int comparisons = 0;
  int waited;
  logic [36:0] got;
  // 100 MHz clock
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  adcd_core u_adcd_core (.CORE_CLK(core_clk), .RST_N(rst_n), .SAMPLE_VALID(sample_valid),
    .SAMPLE_DATA(sample_data), .SAMPLE_READY(sample_ready), .CONVERT_START(convert_start),
    .SCLK(sclk), .DIN(din), .DOUT(dout), .DOUT_OE(dout_oe));
  adcd_host_model u_adcd_host_model (.clk(core_clk), .cnv(convert_start), .sclk(sclk),
    .din(din), .dout(dout));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [17:0] word(int i);
    return (i == 0) ? 18'h00000 : (i == 1) ? 18'h3ffff : 18'h2aaaa ^ 18'(i);
  endfunction : word
  task automatic chkw(logic [36:0] g, logic [36:0] e, string m);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chkw
  task automatic chkn(int g, int lo, int hi, string m);
    comparisons++;
    if (g < lo || g > hi) begin
      mismatches++;
      $display("unexpected at %0t: %s %0d", $time, m, g);
    end
  endtask : chkn
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    repeat (16) @(posedge core_clk);
    chkw(dout_oe, 0, "oe in reset");
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    chkw({dout_oe, dout, sample_ready}, 3'b111, "after reset");
  endtask : t_reset
  task automatic t_fill();
    int n;
    n = 0;
    sample_valid <= 1'b1;
    sample_data <= word(0);
    repeat (50) begin
      @(posedge core_clk);
      if (sample_ready === 1'b1) begin
        n++;
        sample_data <= word(n);
      end
    end
    sample_valid <= 1'b0;
    chkn(n, adcd_pkg::FIFO_DEPTH + 1, adcd_pkg::FIFO_DEPTH + 1, "fifo capacity");
  endtask : t_fill
  task automatic t_drain();
    for (int i = 0; i <= adcd_pkg::FIFO_DEPTH; i++) begin
      u_adcd_host_model.convert(waited);
      chkn(waited, int'(adcd_pkg::CONV_CYCLES), int'(adcd_pkg::CONV_CYCLES) + 10, "conv");
      chkw(dout, 0, "busy done level");
      u_adcd_host_model.read({1'b0, ~word(i)}, got);
      chkw(got, {word(i), 1'b0, ~word(i)}, "chain data");
      if (i == 0) chkw(sample_ready, 1, "room after pop");
    end
  endtask : t_drain
  task automatic t_stall();
    u_adcd_host_model.convert(waited);
    chkw(dout, 1, "busy held with empty fifo");
  endtask : t_stall
  // reset while a conversion is stalled, then release again
  task automatic t_reset_mid();
    rst_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    chkw({dout_oe, dout, sample_ready}, 3'b010, "in mid-run reset");
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    chkw({dout_oe, dout, sample_ready}, 3'b111, "after mid-run reset");
  endtask : t_reset_mid
  initial begin
    t_reset();
    t_fill();
    t_drain();
    t_stall();
    t_reset_mid();
    test_done();
  end
  // hang guard
  initial begin
    #400us;
    mismatches++;
    test_done();
  end
endmodule : tb_adcd_core
